/* File: design/febs_erase_select.sv */
// Erase block select registers with AHB-Lite slave and erase gate
// What this block does
// - Power-on reset, both standby modes and a low write pin clear the reg.
// - Bits 3 to 0 stay zero while the lower software write enable is clear.
// - Bits 7 to 4 stay zero while the upper software write enable is clear.
// - Only a block whose select bit is 1 may be erased; others are protected.
// - More than one select bit across both registers clears both registers.
// - With flash disabled the register reads zero and ignores writes.
// - The register is 8-bit read/write, bit 7 block 15 down to bit 0 block 8.
// - Bit 0 selects the 32 kbyte block at 0x008000 to 0x00FFFF.
// - Bits 1 to 7 select 64 kbyte blocks from 0x010000 up to 0x07FFFF.
`timescale 1ns/100ps
module febs_erase_select
    import febs_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic flash_write_enable_pin,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic flash_disabled,
    input wire logic erase_req,
    input wire logic [23:0] erase_addr,
    output logic erase_grant,
    output logic erase_deny,
    output logic [7:0] upper_sel,
    output logic [7:0] lower_sel
);
    // ****************************************************
    // Pin synchronisers
    // ****************************************************
    logic fwe_meta_r;
    logic fwe_r;
    logic hws_meta_r;
    logic hws_r;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fwe_meta_r <= 1'b0;
            fwe_r <= 1'b0;
            hws_meta_r <= 1'b0;
            hws_r <= 1'b0;
        end else begin
            fwe_meta_r <= flash_write_enable_pin;
            fwe_r <= fwe_meta_r;
            hws_meta_r <= hw_standby;
            hws_r <= hws_meta_r;
        end
    end

    // ****************************************************
    // Bus address phase
    // ****************************************************
    logic wr_pend_r;
    logic rd_pend_r;
    logic [5:0] idx_r;
    logic accept;

    assign accept = hsel && hready && (htrans == FEBS_HTRANS_NONSEQ);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            idx_r <= '0;
        end else begin
            wr_pend_r <= accept && hwrite;
            rd_pend_r <= accept && !hwrite;
            if (accept) begin
                idx_r <= haddr[FEBS_ADDR_MSB:FEBS_ADDR_LSB];
            end
        end
    end

    function automatic logic hits(input logic [5:0] idx,
                                  input logic [7:0] ofs);
        return idx == ofs[FEBS_ADDR_MSB:FEBS_ADDR_LSB];
    endfunction : hits

    // ****************************************************
    // Register next values
    // ****************************************************
    logic [7:0] upper_r;
    logic [7:0] lower_r;
    logic swe_lower_r;
    logic swe_upper_r;
    logic [7:0] upper_nxt;
    logic [7:0] lower_nxt;
    logic clear_all;
    logic wr_ok;

    function automatic logic many(input logic [15:0] v);
        return (v & (v - 16'h0001)) != 16'h0000;
    endfunction : many

    assign wr_ok = wr_pend_r && !flash_disabled;
    assign clear_all = hws_r || sw_standby || !fwe_r;

    always_comb begin
        upper_nxt = upper_r;
        lower_nxt = lower_r;
        // write lands at data phase end
        if (wr_ok && hits(idx_r, FEBS_OFS_UPPER)) begin
            upper_nxt = hwdata[7:0];
        end
        if (wr_ok && hits(idx_r, FEBS_OFS_LOWER)) begin
            lower_nxt = hwdata[7:0];
        end
        // lower write enable gates bits 3..0
        if (!swe_lower_r) begin
            upper_nxt[FEBS_LOWER_HALF_MSB:0] = '0;
            lower_nxt = '0;
        end
        // upper write enable gates bits 7..4
        if (!swe_upper_r) begin
            upper_nxt[7:FEBS_UPPER_HALF_LSB] = '0;
        end
        // more than one bit clears both
        if (many({upper_nxt, lower_nxt})) begin
            upper_nxt = '0;
            lower_nxt = '0;
        end
        if (clear_all) begin
            upper_nxt = '0;
            lower_nxt = '0;
        end
    end

    // ****************************************************
    // Registers
    // ****************************************************
    // 8-bit read/write upper and lower select registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            upper_r <= FEBS_SEL_RESET;
            lower_r <= FEBS_SEL_RESET;
        end else begin
            upper_r <= upper_nxt;
            lower_r <= lower_nxt;
        end
    end

    // write enables only set while the pin is high
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            swe_lower_r <= 1'b0;
            swe_upper_r <= 1'b0;
        end else if (clear_all) begin
            swe_lower_r <= 1'b0;
            swe_upper_r <= 1'b0;
        end else if (wr_ok && hits(idx_r, FEBS_OFS_CTRL)) begin
            swe_lower_r <= hwdata[FEBS_CTRL_SWE_LOWER];
            swe_upper_r <= hwdata[FEBS_CTRL_SWE_UPPER];
        end
    end

    // ****************************************************
    // Read data, one wait state on reads
    // ****************************************************
    logic [31:0] rd_val;

    always_comb begin
        rd_val = '0;
        if (!flash_disabled && hits(idx_r, FEBS_OFS_UPPER)) begin
            rd_val[7:0] = upper_r;
        end
        if (!flash_disabled && hits(idx_r, FEBS_OFS_LOWER)) begin
            rd_val[7:0] = lower_r;
        end
        if (hits(idx_r, FEBS_OFS_CTRL)) begin
            rd_val[FEBS_CTRL_SWE_LOWER] = swe_lower_r;
            rd_val[FEBS_CTRL_SWE_UPPER] = swe_upper_r;
        end
        if (hits(idx_r, FEBS_OFS_STATUS)) begin
            rd_val[FEBS_STAT_PIN] = fwe_r;
            rd_val[FEBS_STAT_DISABLED] = flash_disabled;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'b1;
            hrdata <= '0;
            hresp <= FEBS_HRESP_OKAY;
        end else begin
            hresp <= FEBS_HRESP_OKAY;
            if (accept && !hwrite) begin
                hreadyout <= 1'b0;
            end else if (rd_pend_r) begin
                hreadyout <= 1'b1;
                hrdata <= rd_val;
            end
        end
    end

    // ****************************************************
    // Erase gate
    // ****************************************************
    logic dec_req;
    logic [FEBS_NUM_BLOCKS-1:0] dec_hit;

    febs_block_decode u_decode (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .req(erase_req),
        .addr(erase_addr),
        .req_r(dec_req),
        .hit_r(dec_hit)
    );

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            erase_grant <= 1'b0;
            erase_deny <= 1'b0;
            upper_sel <= '0;
            lower_sel <= '0;
        end else begin
            // grant only for a selected block
            erase_grant <= dec_req && |(dec_hit & {upper_r, lower_r});
            erase_deny <= dec_req && !(|(dec_hit & {upper_r, lower_r}));
            upper_sel <= upper_r;
            lower_sel <= lower_r;
        end
    end
endmodule : febs_erase_select

/* File: design/febs_pkg.sv */
// Package with offsets, fields and reset values for the erase block select
package febs_pkg;
    // ****************************************************
    // Register map
    // ****************************************************
    localparam logic [7:0] FEBS_OFS_UPPER = 8'h00;
    localparam logic [7:0] FEBS_OFS_CTRL = 8'h04;
    localparam logic [7:0] FEBS_OFS_LOWER = 8'h08;
    localparam logic [7:0] FEBS_OFS_STATUS = 8'h0C;
    localparam int FEBS_ADDR_LSB = 2;
    localparam int FEBS_ADDR_MSB = 7;
    // ****************************************************
    // Fields and reset values
    // ****************************************************
    localparam logic [7:0] FEBS_SEL_RESET = 8'h00;
    localparam int FEBS_CTRL_SWE_LOWER = 0;
    localparam int FEBS_CTRL_SWE_UPPER = 1;
    localparam int FEBS_STAT_PIN = 0;
    localparam int FEBS_STAT_DISABLED = 1;
    localparam int FEBS_LOWER_HALF_MSB = 3;
    localparam int FEBS_UPPER_HALF_LSB = 4;
    // ****************************************************
    // Flash block layout
    // ****************************************************
    localparam int FEBS_NUM_BLOCKS = 16;
    localparam logic [23:0] FEBS_SMALL_LIMIT = 24'h008000;
    localparam logic [23:0] FEBS_MID_BASE = 24'h008000;
    localparam logic [23:0] FEBS_BIG_BASE = 24'h010000;
    localparam logic [23:0] FEBS_FLASH_END = 24'h07FFFF;
    localparam int FEBS_SMALL_SHIFT = 12;
    localparam int FEBS_BIG_SHIFT = 16;
    localparam logic [1:0] FEBS_HTRANS_NONSEQ = 2'h2;
    localparam logic FEBS_HRESP_OKAY = 1'b0;
endpackage : febs_pkg

/* File: design/febs_block_decode.sv */
// Erase address to one-hot flash block decoder
`timescale 1ns/100ps
module febs_block_decode
    import febs_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic req,
    input wire logic [23:0] addr,
    output logic req_r,
    output logic [FEBS_NUM_BLOCKS-1:0] hit_r
);
    // ****************************************************
    // Address decode
    // ****************************************************
    function automatic logic [FEBS_NUM_BLOCKS-1:0] decode(
        input logic [23:0] a
    );
        logic [FEBS_NUM_BLOCKS-1:0] h;
        h = '0;
        if (a < FEBS_SMALL_LIMIT) begin
            h[a[14:FEBS_SMALL_SHIFT]] = 1'b1;
        end else if (a < FEBS_BIG_BASE) begin
            h[8] = 1'b1;
        end else if (a <= FEBS_FLASH_END) begin
            h[{1'b1, a[18:FEBS_BIG_SHIFT]}] = 1'b1;
        end
        return h;
    endfunction : decode

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_r <= 1'b0;
            hit_r <= '0;
        end else begin
            req_r <= req;
            hit_r <= decode(addr);
        end
    end
endmodule : febs_block_decode

/* File: dv/febs_erase_select_asserts.sv */
// Checker of the erase block select ports
`timescale 1ns/100ps
module febs_erase_select_asserts
    import febs_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic flash_write_enable_pin,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic flash_disabled,
    input wire logic erase_req,
    input wire logic erase_grant,
    input wire logic erase_deny,
    input wire logic [7:0] upper_sel,
    input wire logic [7:0] lower_sel
);
    // ****************************************************
    // Properties
    // ****************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    sequence s_rd;
        hsel && hready && htrans == FEBS_HTRANS_NONSEQ && !hwrite;
    endsequence
    sequence s_rd_off;
        hsel && hready && htrans == FEBS_HTRANS_NONSEQ && !hwrite &&
            flash_disabled && haddr[7:2] == 6'h0 ##1 flash_disabled;
    endsequence
    a_read_wait: assert property (s_rd |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_off_zero: assert property (s_rd_off |=> hrdata == 32'h0)
        else $error("disabled read not zero");
    a_resp_okay: assert property (hresp == FEBS_HRESP_OKAY)
        else $error("response not okay");
    a_one_hot: assert property ($onehot0({upper_sel, lower_sel}))
        else $error("more than one select bit");
    a_sw_standby: assert property (sw_standby |->
        ##2 (upper_sel == 8'h0 && lower_sel == 8'h0))
        else $error("standby did not clear");
    a_pin_clears: assert property (
        !flash_write_enable_pin || hw_standby |->
        ##4 (upper_sel == 8'h0 && lower_sel == 8'h0))
        else $error("pin or standby did not clear");
    a_erase_answer: assert property (erase_req |->
        ##2 (erase_grant ^ erase_deny))
        else $error("erase answer missing");
    a_erase_quiet: assert property (!erase_req |->
        ##2 (!erase_grant && !erase_deny))
        else $error("erase answer without request");
endmodule : febs_erase_select_asserts
bind febs_erase_select febs_erase_select_asserts u_chk (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .flash_write_enable_pin(flash_write_enable_pin),
    .hw_standby(hw_standby),
    .sw_standby(sw_standby),
    .flash_disabled(flash_disabled),
    .erase_req(erase_req),
    .erase_grant(erase_grant),
    .erase_deny(erase_deny),
    .upper_sel(upper_sel),
    .lower_sel(lower_sel)
);

/* File: dv/testbench.sv */
// Self-checking bench for the erase block select
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
$display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module testbench import febs_pkg::*;;
    logic core_clk = 0, arst_n = 0, hsel = 0, hwrite = 0, rd_dph = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rnd = 32'hB355;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, erase_grant, erase_deny, erase_req = 0;
    logic flash_write_enable_pin = 0, hw_standby = 0, sw_standby = 0;
    logic flash_disabled = 0;
    logic [23:0] erase_addr = 0;
    logic [7:0] upper_sel, lower_sel;
    logic [31:0] exp_rd[$], exp_er[$];
    int num_errors = 0, n_checks = 0;
    wire hready = hreadyout;
    febs_erase_select dut (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .flash_write_enable_pin(flash_write_enable_pin),
        .hw_standby(hw_standby),
        .sw_standby(sw_standby),
        .flash_disabled(flash_disabled),
        .erase_req(erase_req),
        .erase_addr(erase_addr),
        .erase_grant(erase_grant),
        .erase_deny(erase_deny),
        .upper_sel(upper_sel),
        .lower_sel(lower_sel)
    );
    initial forever #4 core_clk = ~core_clk;
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction : xs
    // ****************************************************
    // Monitor and bus tasks
    // ****************************************************
    always @(posedge core_clk) begin : mon
        logic [31:0] e;
        if (rd_dph && hreadyout) begin
            e = exp_rd.pop_front();
            `CHK(hrdata, e)
            rd_dph = 0;
        end
        if (hsel && hready && htrans == FEBS_HTRANS_NONSEQ && !hwrite) begin
            rd_dph = 1;
        end
        if (erase_grant || erase_deny) begin
            e = exp_er.pop_front();
            `CHK({30'h0, erase_grant, erase_deny}, e)
        end
    end
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    task automatic wait_rdy();
        int i;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (!hready && i < 64);
        if (!hready) begin
            `CHK(hready, 1'b1)
            final_report();
        end
    endtask : wait_rdy
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        hsel <= 1;
        htrans <= FEBS_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask : bus
    task automatic rd(logic [7:0] a, logic [31:0] e);
        exp_rd.push_back(e);
        bus(0, a, 32'h0);
    endtask : rd
    task automatic er(logic [23:0] a, logic g);
        erase_req <= 1;
        erase_addr <= a;
        exp_er.push_back({30'h0, g, !g});
        tick(1);
        erase_req <= 0;
        tick(1);
    endtask : er
    initial begin
        logic [31:0] r;
        logic [23:0] ea;
        tick(12);
        arst_n <= 1;
        flash_write_enable_pin <= 1;
        tick(4);
        bus(1, FEBS_OFS_UPPER, 32'h10);
        rd(FEBS_OFS_UPPER, 32'h0);
        bus(1, FEBS_OFS_UPPER, 32'h1);
        rd(FEBS_OFS_UPPER, 32'h0);
        rd(8'h10, 32'h0);
        rd(FEBS_OFS_STATUS, 32'h1);
        $display("test gating done");
        bus(1, FEBS_OFS_CTRL, 32'h3);
        for (int k = 0; k < 8; k++) begin
            bus(1, FEBS_OFS_UPPER, 32'h1 << k);
            rd(FEBS_OFS_UPPER, 32'h1 << k);
            r = xs();
            ea = {4'h0, k[3:0], r[15:0]};
            if (k == 0) begin
                ea = 24'h008000 | {9'h0, r[14:0]};
            end
            er(ea, 1);
            er(24'h080000 | {5'h0, r[18:0]}, 0);
            er({12'h0, r[11:0]}, 0);
        end
        $display("test blocks done");
        bus(1, FEBS_OFS_LOWER, 32'h1);
        rd(FEBS_OFS_UPPER, 32'h0);
        rd(FEBS_OFS_LOWER, 32'h0);
        bus(1, FEBS_OFS_UPPER, 32'h2);
        flash_disabled <= 1;
        bus(1, FEBS_OFS_UPPER, 32'h4);
        rd(FEBS_OFS_UPPER, 32'h0);
        flash_disabled <= 0;
        rd(FEBS_OFS_UPPER, 32'h2);
        $display("test shared and disabled done");
        for (int s = 0; s < 3; s++) begin
            bus(1, FEBS_OFS_CTRL, 32'h3);
            bus(1, FEBS_OFS_UPPER, 32'h20);
            rd(FEBS_OFS_UPPER, 32'h20);
            sw_standby <= s == 0;
            hw_standby <= s == 1;
            flash_write_enable_pin <= s != 2;
            tick(3);
            sw_standby <= 0;
            hw_standby <= 0;
            flash_write_enable_pin <= 1;
            tick(4);
            rd(FEBS_OFS_UPPER, 32'h0);
            rd(FEBS_OFS_CTRL, 32'h0);
        end
        $display("test clears done");
        bus(1, FEBS_OFS_CTRL, 32'h3);
        bus(1, FEBS_OFS_UPPER, 32'h20);
        arst_n <= 0;
        tick(2);
        arst_n <= 1;
        tick(4);
        rd(FEBS_OFS_UPPER, 32'h0);
        rd(FEBS_OFS_CTRL, 32'h0);
        $display("test reset done");
        tick(4);
        `CHK(exp_rd.size() + exp_er.size(), 0)
        final_report();
    end
endmodule : testbench
